// *** hw/adcc_chan_dec.sv ***
/*
 * Decodes the mode and channel configuration into analog input enables and mode flags.
 * Assumes the configuration register value is stable between host writes.
 */
`timescale 1ns/10ps
module adcc_chan_dec
	import adcc_pkg::*;
(
	// Configuration.
	input wire logic [ADCC_CFG_W-1:0] i_mode_cfg,
	// Decoded selection.
	output logic [3:0] o_chan_en,
	output logic o_dual,
	output logic o_continuous,
	output logic o_bipolar
);
	logic diff;
	logic hi;
	logic lo;

	always_comb
	begin
		diff = i_mode_cfg[ADCC_INPUT_TYPE_BIT];
		hi = i_mode_cfg[ADCC_CHSEL_HI_BIT];
		lo = i_mode_cfg[ADCC_CHSEL_LO_BIT];
		o_dual = i_mode_cfg[ADCC_MODE_DUAL_BIT];
		o_continuous = i_mode_cfg[ADCC_MODE_CONT_BIT];
		o_bipolar = diff;
		// Pair A sits on inputs one and two, pair B on three and four.
		if (o_dual && diff)
			o_chan_en = 4'hF;
		else if (o_dual)
			o_chan_en = lo ? 4'hA : 4'h5;
		else if (diff)
			o_chan_en = hi ? 4'hC : 4'h3;
		else
			o_chan_en = 4'h1 << {hi, lo};
	end
endmodule // adcc_chan_dec

// *** hw/adcc_ctrl.sv ***
/*
 * Converter control top: parallel host bus with two configuration registers,
 * power-down readback, conversion sequencing and end-of-conversion output.
 * Assumes all pins are synchronous to i_clk_sys and the conversion clock is sampled as a level.
 */
`timescale 1ns/10ps
module adcc_ctrl
	import adcc_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// Host bus strobes.
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_sample_trigger_n,
	// Data bus pin.
	input wire logic [ADCC_BUS_W-1:0] i_data,
	output logic [ADCC_BUS_W-1:0] o_data,
	output logic o_data_oe,
	// End-of-conversion open-drain pin.
	output logic o_eoc_n,
	output logic o_eoc_oe,
	// Analog core.
	input wire logic i_conversion_clock,
	input wire logic [1:0] i_result_pair,
	output logic o_conv_busy,
	output logic [3:0] o_chan_en,
	output logic o_dual,
	output logic o_continuous,
	output logic o_bipolar,
	output logic o_power_down
);
	logic [3:0] rise;
	logic [3:0] fall;
	logic cs_fall;
	logic cs_rise;
	logic rd_fall;
	logic rd_rise;
	logic wr_rise;
	logic trig_rise;
	logic clk_fall;
	logic cs_low;
	logic [ADCC_CFG_W-1:0] mode_cfg_q;
	logic [ADCC_CFG_W-1:0] out_cfg_q;
	logic pd_q;
	adcc_rb_t rb_q;
	logic busy_q;
	logic [2:0] beat_q;
	logic [7:0] acc_q;
	logic [ADCC_BUS_W-1:0] result_q;
	logic eoc_q;
	logic [ADCC_BUS_W-1:0] data_d;
	logic [ADCC_BUS_W-1:0] data_q;
	logic start;
	logic last_beat;
	logic [ADCC_BUS_W-1:0] word;
	logic [3:0] chan_en;
	logic dual;
	logic cont;
	logic bip;
	logic [2:0] fall_cnt_q;

	// The conversion clock is treated as a slow level so each level must hold for at least one system clock to show an edge.
	adcc_edge #(
		.N(4)
	) u_edge (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_level({i_conversion_clock, i_sample_trigger_n, i_wr_n, i_rd_n}),
		.o_rise(rise),
		.o_fall(fall)
	);

	adcc_edge #(
		.N(1)
	) u_cs_edge (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_level(i_cs_n),
		.o_rise(cs_rise),
		.o_fall(cs_fall)
	);

	adcc_chan_dec u_dec (
		.i_mode_cfg(mode_cfg_q),
		.o_chan_en(chan_en),
		.o_dual(dual),
		.o_continuous(cont),
		.o_bipolar(bip)
	);

	assign cs_low = ~i_cs_n;
	assign rd_fall = fall[0] & cs_low;
	assign rd_rise = rise[0];
	assign wr_rise = rise[1] & cs_low;
	assign trig_rise = rise[2];
	assign clk_fall = fall[3];
	assign pd_q = out_cfg_q[ADCC_POWER_DOWN_BIT];
	// The trigger pin works without chip select; a read fall in power-down is ignored.
	assign start = ~pd_q & (rd_fall | trig_rise);
	assign last_beat = busy_q & clk_fall & (beat_q == ADCC_CONV_BEATS - 3'h1);
	assign word = {acc_q, i_result_pair};

	// Configuration write: index in the top two bits, all eight data bits at once.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			mode_cfg_q <= ADCC_MODE_CFG_RESET;
			out_cfg_q <= ADCC_OUT_CFG_RESET;
		end
		else if (wr_rise)
		begin
			if (i_data[9:8] == ADCC_IDX_MODE_CFG)
				mode_cfg_q <= i_data[7:0] & ~ADCC_MODE_CFG_ZERO_MASK;
			else if (i_data[9:8] == ADCC_IDX_OUT_CFG)
				out_cfg_q <= i_data[7:0] & ~ADCC_OUT_CFG_ZERO_MASK;
		end
	end

	// Readback walks the two registers on read rising edges while powered down.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset || cs_fall || !pd_q)
			rb_q <= ADCC_RB_FIRST;
		else if (rd_rise)
		begin
			case (rb_q)
				ADCC_RB_FIRST: rb_q <= ADCC_RB_SECOND;
				ADCC_RB_SECOND: rb_q <= ADCC_RB_DONE;
				default: rb_q <= ADCC_RB_DONE;
			endcase
		end
	end

	// Conversion sequencer: one pair of bits per falling conversion clock edge.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset || cs_fall)
		begin
			busy_q <= 1'b0;
			beat_q <= 3'h0;
			acc_q <= 8'h00;
		end
		else if (start)
		begin
			busy_q <= 1'b1;
			beat_q <= 3'h0;
			acc_q <= 8'h00;
		end
		else if (busy_q && clk_fall)
		begin
			acc_q <= word[7:0];
			beat_q <= beat_q + 3'h1;
			if (last_beat)
				busy_q <= 1'b0;
		end
	end

	// Parallel result word; bipolar results flip the top bit into two's complement.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			result_q <= 10'h000;
		else if (last_beat)
			result_q <= bip ? {~word[9], word[8:0]} : word;
	end

	// End of conversion is sticky; a completion in the same cycle as a release wins.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			eoc_q <= 1'b0;
		else if (last_beat)
			eoc_q <= 1'b1;
		else if (cs_rise || rd_rise || cs_fall)
			eoc_q <= 1'b0;
	end

	always_comb
	begin
		if (!pd_q)
			data_d = result_q;
		else if (rb_q == ADCC_RB_FIRST)
			data_d = {2'h0, mode_cfg_q};
		else if (rb_q == ADCC_RB_SECOND)
			data_d = {2'h0, out_cfg_q};
		else
			data_d = 10'h000;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			data_q <= 10'h000;
		else
			data_q <= data_d;
	end

	// Only reads drive the bus; during a write the host owns it, so driving would contend.
	assign o_data_oe = cs_low & ~i_rd_n & ~i_reset;
	assign o_data = data_q;
	assign o_eoc_n = 1'b0;
	assign o_eoc_oe = eoc_q;
	assign o_conv_busy = busy_q;
	assign o_chan_en = chan_en;
	assign o_dual = dual;
	assign o_continuous = cont;
	assign o_bipolar = bip;
	assign o_power_down = pd_q;

	// Separate count of conversion clock falls, so the beat checks do not lean on the sequencer counter.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset || cs_fall || start)
			fall_cnt_q <= 3'h0;
		else if (busy_q && clk_fall)
			fall_cnt_q <= fall_cnt_q + 3'h1;
	end

	property p_five_beats;
		@(posedge i_clk_sys) disable iff (i_reset)
		($fell(busy_q) && !$past(cs_fall) && !$past(i_reset))
			|-> ($past(clk_fall) && $past(fall_cnt_q) == ADCC_CONV_BEATS - 3'h1);
	endproperty

	AST_FIVE_BEATS: assert property (p_five_beats)
		else $error("Conversion dropped busy early.");

	AST_DONE_AT_FIFTH: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		last_beat |-> fall_cnt_q == ADCC_CONV_BEATS - 3'h1)
		else $error("Conversion ended on the wrong beat.");

	AST_RESULT_WORD: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(last_beat && !bip) |=> result_q == $past(word))
		else $error("Result word not gathered.");

	AST_BIPOLAR: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(last_beat && bip) |=> result_q[9] != $past(word[9]))
		else $error("Bipolar result not converted.");

	AST_WRITE_MODE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(wr_rise && i_data[9:8] == ADCC_IDX_MODE_CFG) |=> mode_cfg_q == $past(i_data[7:0]))
		else $error("Mode register not written.");

	AST_WRITE_OUT: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(wr_rise && i_data[9:8] == ADCC_IDX_OUT_CFG) |=> out_cfg_q == $past(i_data[7:0]))
		else $error("Output register not written.");

	AST_NO_WRITE_CS_HIGH: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(i_cs_n && !wr_rise) |=> $stable(mode_cfg_q) && $stable(out_cfg_q))
		else $error("Register changed without a write.");

	AST_PD_NO_START: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(pd_q && !busy_q && !cs_fall) |=> !busy_q)
		else $error("Conversion started in power-down.");

	AST_OE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		o_data_oe |-> (!i_cs_n && !i_rd_n))
		else $error("Bus driven outside a read.");

	AST_CS_RESET: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		cs_fall |=> !busy_q && beat_q == 3'h0)
		else $error("Chip select did not reset control.");

	AST_EOC_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(o_eoc_oe && !cs_rise && !rd_rise && !cs_fall) |=> o_eoc_oe)
		else $error("End of conversion released early.");

	AST_READBACK: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(pd_q && rb_q == ADCC_RB_FIRST && !cs_fall) |=> data_q == {2'h0, $past(mode_cfg_q)})
		else $error("First readback word wrong.");

	AST_DUAL_DIFF: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(dual && bip) |-> o_chan_en == 4'hF)
		else $error("Dual differential must use both pairs.");

	CV_CONVERSION: cover property (@(posedge i_clk_sys) disable iff (i_reset) last_beat);
	CV_READBACK: cover property (@(posedge i_clk_sys) disable iff (i_reset)
		pd_q && rd_rise && rb_q == ADCC_RB_SECOND);
	CV_EOC_RELEASE: cover property (@(posedge i_clk_sys) disable iff (i_reset) o_eoc_oe && rd_rise);
endmodule // adcc_ctrl

// *** hw/adcc_edge.sv ***
/*
 * Registered edge detector for a group of synchronous input levels.
 * Assumes inputs are already synchronous to the system clock.
 */
`timescale 1ns/10ps
module adcc_edge #(
	parameter int N = 4
) (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// Levels and their edges.
	input wire logic [N-1:0] i_level,
	output logic [N-1:0] o_rise,
	output logic [N-1:0] o_fall
);
	logic [N-1:0] prev_q;

	// Reset to all ones since every watched pin idles high.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			prev_q <= '1;
		else
			prev_q <= i_level;
	end

	for (genvar g = 0; g < N; g++)
	begin : g_edge
		assign o_rise[g] = i_level[g] & ~prev_q[g];
		assign o_fall[g] = ~i_level[g] & prev_q[g];
	end
endmodule // adcc_edge

// *** hw/adcc_pkg.sv ***
/*
 * Constants shared by the converter control block: register indices, field positions,
 * conversion beat count and readback sequence codes.
 * Assumes a single synchronous system clock and a host that programs both registers before use.
 */
package adcc_pkg;
	localparam int ADCC_BUS_W = 10;
	localparam int ADCC_CFG_W = 8;
	localparam logic [1:0] ADCC_IDX_MODE_CFG = 2'h0;
	localparam logic [1:0] ADCC_IDX_OUT_CFG = 2'h1;
	localparam int ADCC_INPUT_TYPE_BIT = 4;
	localparam int ADCC_MODE_CONT_BIT = 3;
	localparam int ADCC_MODE_DUAL_BIT = 2;
	localparam int ADCC_CHSEL_HI_BIT = 1;
	localparam int ADCC_CHSEL_LO_BIT = 0;
	localparam int ADCC_POWER_DOWN_BIT = 7;
	localparam logic [7:0] ADCC_MODE_CFG_RESET = 8'h00;
	localparam logic [7:0] ADCC_OUT_CFG_RESET = 8'h00;
	localparam logic [7:0] ADCC_MODE_CFG_ZERO_MASK = 8'h00;
	localparam logic [7:0] ADCC_OUT_CFG_ZERO_MASK = 8'h00;
	localparam logic [2:0] ADCC_CONV_BEATS = 3'h5;
	typedef enum logic [1:0]
	{
		ADCC_RB_FIRST = 2'b00,
		ADCC_RB_SECOND = 2'b01,
		ADCC_RB_DONE = 2'b10
	} adcc_rb_t;
endpackage

// *** tb/adcc_ctrl_test.sv ***
/*
 * Self-checking bench for the converter control block with host and analog core models.
 * Assumes the design's hand-over timing; the conversion clock stands high between conversions.
 */
`timescale 1ns/10ps
module adcc_ctrl_test;
	import adcc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cs_n, rd_n, wr_n, trig_n, wdata_oe, data_oe, eoc_n, eoc_oe, busy;
	logic dual, cont, bip, pd;
	logic eoc_wait = 1'b0;
	logic eoc_prev = 1'b0;
	logic conv_clk = 1'b1;
	logic [1:0] res_pair = 2'h0;
	logic [9:0] wdata, o_data, data_bus;
	logic [9:0] bus_last = 10'h000;
	logic [3:0] chan_en;
	logic [9:0] exp_q[$];
	logic [31:0] seed = 32'h0000003A;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	initial
	begin
		forever #10 clk = ~clk;
	end
	// An undriven wire must not echo the last value, so it shows the inverse.
	assign data_bus = data_oe ? o_data : (wdata_oe ? wdata : ~bus_last);
	always @(posedge clk) bus_last <= data_bus;
	adcc_host_model i_host (.i_clk_sys(clk), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
		.o_trig_n(trig_n), .o_wdata(wdata), .o_wdata_oe(wdata_oe));
	adcc_ctrl i_dut (.i_clk_sys(clk), .i_reset(rst), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
		.i_sample_trigger_n(trig_n), .i_data(data_bus), .o_data(o_data), .o_data_oe(data_oe),
		.o_eoc_n(eoc_n), .o_eoc_oe(eoc_oe), .i_conversion_clock(conv_clk), .i_result_pair(res_pair),
		.o_conv_busy(busy), .o_chan_en(chan_en), .o_dual(dual), .o_continuous(cont),
		.o_bipolar(bip), .o_power_down(pd));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [3:0] exp_chan(input logic [4:0] c);
		if (c[2])
			return c[4] ? 4'hF : (c[0] ? 4'hA : 4'h5);
		return c[4] ? (c[1] ? 4'hC : 4'h3) : (4'h1 << c[1:0]);
	endfunction
	task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Monitor: the word that follows each completion is compared with the oldest expectation.
	always @(negedge clk)
	begin
		if (eoc_wait === 1'b1 && exp_q.size() > 0)
			check("result", o_data, exp_q.pop_front());
		eoc_wait = eoc_oe & ~eoc_prev;
		eoc_prev = eoc_oe;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic convert(input logic bipolar);
		logic [9:0] w;
		w = 10'(rnd());
		exp_q.push_back(bipolar ? w ^ 10'h200 : w);
		i_host.strobe(1'b0, 1'b0);
		// The bipolar run starts on a read fall with chip select already low, the other on the trigger pin.
		if (bipolar)
		begin
			i_host.strobe(1'b0, 1'b1);
			i_host.strobe(1'b0, 1'b0);
		end
		else
			i_host.pulse_trig();
		for (int k = 0; k < 5; k++)
		begin
			@(negedge clk);
			res_pair = w[9 - 2 * k -: 2];
			conv_clk = 1'b0;
			repeat (3) @(negedge clk);
			conv_clk = 1'b1;
			if (k == 3)
			begin
				check("eoc early", eoc_oe, 1'b0);
				check("busy", busy, 1'b1);
			end
			repeat (2) @(negedge clk);
		end
		check("eoc", eoc_oe, 1'b1);
		check("eoc pin", eoc_n, 1'b0);
		check("busy done", busy, 1'b0);
		i_host.strobe(1'b1, 1'b1);
		repeat (2) @(negedge clk);
		check("eoc release", eoc_oe, 1'b0);
		check("bus idle", data_oe, 1'b0);
	endtask
	initial
	begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		for (int c = 0; c < 32; c++)
		begin
			i_host.write_reg(ADCC_IDX_MODE_CFG, {3'(rnd()), 5'(c)}, 1'b1);
			i_host.write_reg(ADCC_IDX_OUT_CFG, 8'(rnd()) & 8'h7F, 1'b1);
			repeat (2) @(negedge clk);
			check("chan", chan_en, exp_chan(5'(c)));
			check("dual", dual, c[2]);
			check("cont", cont, c[3]);
			check("bipolar", bip, c[4]);
			check("pd", pd, 1'b0);
		end
		i_host.write_reg(2'h2, 8'h00, 1'b1);
		i_host.write_reg(ADCC_IDX_MODE_CFG, 8'h00, 1'b0);
		repeat (2) @(negedge clk);
		check("refused", chan_en, 4'hF);
		// Both registers are programmed before any trigger.
		i_host.write_reg(ADCC_IDX_MODE_CFG, 8'h00, 1'b1);
		i_host.write_reg(ADCC_IDX_OUT_CFG, 8'h00, 1'b1);
		convert(1'b0);
		i_host.write_reg(ADCC_IDX_MODE_CFG, 8'h10, 1'b1);
		convert(1'b1);
		i_host.write_reg(ADCC_IDX_MODE_CFG, 8'h5A, 1'b1);
		i_host.write_reg(ADCC_IDX_OUT_CFG, 8'hC3, 1'b1);
		i_host.strobe(1'b0, 1'b0);
		repeat (3) @(negedge clk);
		check("readback 0", o_data, 10'h05A);
		check("rd oe", data_oe, 1'b1);
		check("pd busy", busy, 1'b0);
		check("pd on", pd, 1'b1);
		i_host.strobe(1'b0, 1'b1);
		repeat (2) @(negedge clk);
		i_host.strobe(1'b0, 1'b0);
		@(negedge clk);
		check("readback 1", o_data, 10'h0C3);
		check("pd rd", busy, 1'b0);
		i_host.pulse_trig();
		repeat (2) @(negedge clk);
		check("pd trig", busy, 1'b0);
		i_host.strobe(1'b1, 1'b1);
		repeat (4) @(negedge clk);
		check("readback end", o_data, 10'h000);
		check("results pending", 10'(exp_q.size()), 10'h000);
		tally_and_finish();
	end
endmodule // adcc_ctrl_test

// *** tb/adcc_host_model.sv ***
/*
 * Host model: drives chip select, strobes, trigger and write data of the converter bus.
 * Assumes the bench resolves the shared data wire and calls these tasks one at a time.
 */
`timescale 1ns/10ps
module adcc_host_model (
	// Clock.
	input wire logic i_clk_sys,
	// Bus strobes and write data.
	output logic o_cs_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic o_trig_n,
	output logic [9:0] o_wdata,
	output logic o_wdata_oe
);
	initial
	begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_trig_n = 1'b1;
		o_wdata = 10'h000;
		o_wdata_oe = 1'b0;
	end
	// Index and data travel as one word, held until after the strobe rise is sampled.
	task automatic write_reg(input logic [1:0] idx, input logic [7:0] val, input logic sel);
		@(negedge i_clk_sys);
		o_cs_n = ~sel;
		o_wr_n = 1'b0;
		o_wdata = {idx, val};
		o_wdata_oe = 1'b1;
		@(negedge i_clk_sys);
		o_wr_n = 1'b1;
		@(negedge i_clk_sys);
		o_wdata_oe = 1'b0;
		o_cs_n = 1'b1;
	endtask
	task automatic strobe(input logic cs, input logic rd);
		@(negedge i_clk_sys);
		o_cs_n = cs;
		o_rd_n = rd;
	endtask
	task automatic pulse_trig();
		@(negedge i_clk_sys);
		o_trig_n = 1'b0;
		@(negedge i_clk_sys);
		o_trig_n = 1'b1;
	endtask
endmodule // adcc_host_model
